// ==== inc/mcd_pkg.sv ====
// Shared types, constants and complex arithmetic for the MISO estimator and pair decoder.
// Behaviour
// - Pilots are sorted into sum and difference classes, each measured on its own.
// - Group-one response is sum plus difference; group-two response is sum minus difference.
// - Sum and difference are interpolated over time and frequency for every cell.
// - Each symbol holds one pilot class, so the other always comes from time interpolation.
// - Every frame ends in a closing symbol that serves as the last time reference.
// - Edge carriers take one class directly and the other from neighbouring symbols.
// - Closing-symbol edge: hold last value, or use the next frame if no foreign part.
// - Frequency interpolation assumes half the single-transmitter delay range.
// - Pairs are consecutive data cells in frequency, regardless of the pipe they carry.
// - Received vector is first cell and conjugated second cell, combined by H transposed.
// - Pair decoding is built so several receive antennas could be summed in.
// - Zero-forcing uses four distinct channel values and inverts the full matrix.
// - MMSE applies H transposed, then inverts the Gram matrix plus noise variance.
// - A pilot between pair cells does not matter: each cell uses its own carrier.
// - Guard fractions above one eighth are not supported in this mode.
package mcd_pkg;

  localparam int CW = 16;
  localparam int FRAC = 14;
  localparam int NCAR = 64;
  localparam int AW = 6;
  localparam logic CLS_SUM = 1'b0;
  localparam logic CLS_DIFF = 1'b1;

  typedef struct packed {
    logic signed [CW-1:0] re;
    logic signed [CW-1:0] im;
  } mcd_cpx_t;

  typedef enum logic [1:0] {MCD_DEC_CT, MCD_DEC_ZF, MCD_DEC_MMSE} mcd_dec_mode_t;

  typedef enum logic [2:0] {
    MCD_GI_1_128, MCD_GI_1_32, MCD_GI_1_16, MCD_GI_19_256,
    MCD_GI_1_8, MCD_GI_19_128, MCD_GI_1_4
  } mcd_gi_t;

  localparam mcd_gi_t MCD_GI_LIMIT = MCD_GI_1_8;

  typedef enum logic {MCD_RUN, MCD_FLUSH} mcd_phase_t;

  typedef struct packed {
    mcd_cpx_t val;
    logic pilot;
    logic sof_frame;
    logic eof_sym;
    logic closing;
  } mcd_cell_in_t;

  typedef struct packed {
    mcd_cpx_t val;
    mcd_cpx_t gain;
  } mcd_cell_out_t;

  typedef struct packed {
    mcd_cpx_t val;
    logic pilot;
    logic eos;
  } mcd_buf_t;

  typedef struct packed {
    mcd_cpx_t s;
    mcd_cpx_t d;
    logic s_tag;
    logic d_tag;
    logic s_ok;
    logic d_ok;
  } mcd_est_t;

  typedef struct packed {
    mcd_phase_t st;
    logic [AW-1:0] k;
    logic [AW:0] len;
    logic have_prev;
    logic cls;
    logic tag;
    logic rdy;
    logic s1_vld;
    logic s1_old;
    logic s1_npil;
    logic s1_ncls;
    logic s1_ntag;
    mcd_cpx_t s1_nval;
    logic [AW-1:0] s1_k;
    mcd_cpx_t fs;
    mcd_cpx_t fd;
    logic s2_vld;
    logic s2_pil;
    logic s2_eos;
    mcd_cpx_t s2_r;
    mcd_cpx_t s2_h1;
    mcd_cpx_t s2_h2;
    logic f_vld;
    mcd_cpx_t f_r;
    mcd_cpx_t f_h1;
    mcd_cpx_t f_h2;
    logic o_vld;
    mcd_cell_out_t o;
    logic p_vld;
    mcd_cell_out_t p;
    logic gi_flt;
  } mcd_top_st_t;

  function automatic mcd_cpx_t mcd_cmul(mcd_cpx_t a, mcd_cpx_t b);
    logic signed [31:0] ar;
    logic signed [31:0] ai;
    logic signed [31:0] br;
    logic signed [31:0] bi;
    logic signed [32:0] pr;
    logic signed [32:0] pi;
    mcd_cpx_t z;
    ar = 32'(a.re);
    ai = 32'(a.im);
    br = 32'(b.re);
    bi = 32'(b.im);
    pr = 33'(ar * br) - 33'(ai * bi);
    pi = 33'(ar * bi) + 33'(ai * br);
    z.re = pr[FRAC+CW-1:FRAC];
    z.im = pi[FRAC+CW-1:FRAC];
    return z;
  endfunction : mcd_cmul

  function automatic mcd_cpx_t mcd_conj(mcd_cpx_t a);
    mcd_cpx_t z;
    z.re = a.re;
    z.im = -a.im;
    return z;
  endfunction : mcd_conj

  function automatic mcd_cpx_t mcd_add(mcd_cpx_t a, mcd_cpx_t b);
    mcd_cpx_t z;
    z.re = a.re + b.re;
    z.im = a.im + b.im;
    return z;
  endfunction : mcd_add

  function automatic mcd_cpx_t mcd_sub(mcd_cpx_t a, mcd_cpx_t b);
    mcd_cpx_t z;
    z.re = a.re - b.re;
    z.im = a.im - b.im;
    return z;
  endfunction : mcd_sub

  function automatic mcd_cpx_t mcd_avg(mcd_cpx_t a, mcd_cpx_t b);
    logic signed [CW:0] sr;
    logic signed [CW:0] si;
    mcd_cpx_t z;
    sr = (CW+1)'(a.re) + (CW+1)'(b.re);
    si = (CW+1)'(a.im) + (CW+1)'(b.im);
    z.re = sr[CW:1];
    z.im = si[CW:1];
    return z;
  endfunction : mcd_avg

  function automatic mcd_cpx_t mcd_mag2(mcd_cpx_t a);
    return mcd_cmul(a, mcd_conj(a));
  endfunction : mcd_mag2

endpackage : mcd_pkg

// ==== logic/mcd_miso_decoder.sv ====
// MISO channel estimation and Alamouti pair decoding between demodulator and de-interleaver.
`timescale 1ns/1ps
module mcd_miso_decoder (
  input wire logic clk, // Datapath clock, 50 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic in_vld, // Input cell valid.
  input wire mcd_pkg::mcd_cell_in_t in_cell, // Cell in carrier order with flags.
  input wire logic fef_between, // A foreign frame part follows this frame.
  input wire mcd_pkg::mcd_dec_mode_t dec_mode, // Pair recombination method.
  input wire logic signed [15:0] noise_var, // Noise variance for MMSE.
  input wire mcd_pkg::mcd_gi_t gi_sel, // Guard interval fraction in use.
  output logic in_ready, // Ready to take a cell.
  output logic out_vld, // Output cell valid.
  output mcd_pkg::mcd_cell_out_t out_cell, // Decoded cell and its gain.
  output logic gi_fault // Guard fraction not supported.
);
  import mcd_pkg::*;

  mcd_top_st_t q;
  mcd_top_st_t n;
  logic acc;
  mcd_buf_t buf_rd;
  mcd_est_t est;
  mcd_est_t est_wr;
  logic tab_we;
  logic [$bits(mcd_buf_t)-1:0] buf_rd_raw;
  logic [$bits(mcd_est_t)-1:0] tab_rd_raw;
  mcd_buf_t buf_wr;

  assign acc = in_vld && q.rdy && (q.st == MCD_RUN);
  assign buf_wr = '{val: in_cell.val, pilot: in_cell.pilot, eos: in_cell.eof_sym};

  // Holds the previous symbol while the next one arrives, so time interpolation can look ahead.
  mcd_ram #(.W($bits(mcd_buf_t)), .DEPTH(NCAR), .AW(AW)) u_sym_buf (
    .clk(clk),
    .arst_n(arst_n),
    .we(acc),
    .waddr(q.k),
    .wdata(buf_wr),
    .raddr(q.k),
    .rdata_q(buf_rd_raw)
  );

  // Latest sum and difference measurement per carrier.
  mcd_ram #(.W($bits(mcd_est_t)), .DEPTH(NCAR), .AW(AW)) u_est_tab (
    .clk(clk),
    .arst_n(arst_n),
    .we(tab_we),
    .waddr(q.s1_k),
    .wdata(est_wr),
    .raddr(q.k),
    .rdata_q(tab_rd_raw)
  );

  assign buf_rd = mcd_buf_t'(buf_rd_raw);
  assign est = mcd_est_t'(tab_rd_raw);

  // Pair decoding; is conjugated into the received vector. Per-antenna y and Gram
  // terms are plain sums, so more antennas add as extra terms.
  mcd_cpx_t h00, h01, h10, h11, r1, r2c;
  mcd_cpx_t y1, y2, g11, g22, g12, nv, a11, a22;
  mcd_cpx_t mm1, mm2, mdet, zf1, zf2, zdet, sgl, sgl_g;
  assign h00 = q.f_h1;
  assign h01 = q.f_h2;
  assign h10 = q.s2_h2;
  assign h11 = q.s2_h1;
  assign r1 = q.f_r;
  assign r2c = mcd_conj(q.s2_r);
  assign y1 = mcd_add(mcd_cmul(mcd_conj(h00), r1), mcd_cmul(h10, r2c));
  assign y2 = mcd_sub(mcd_cmul(h11, r2c), mcd_cmul(mcd_conj(h01), r1));
  assign g11 = mcd_add(mcd_mag2(h00), mcd_mag2(h10));
  assign g22 = mcd_add(mcd_mag2(h01), mcd_mag2(h11));
  assign g12 = mcd_sub(mcd_cmul(h10, mcd_conj(h11)), mcd_cmul(mcd_conj(h00), h01));
  assign nv = '{re: noise_var, im: 16'h0000};
  assign a11 = mcd_add(g11, nv);
  assign a22 = mcd_add(g22, nv);
  assign mm1 = mcd_sub(mcd_cmul(a22, y1), mcd_cmul(g12, y2));
  assign mm2 = mcd_sub(mcd_cmul(a11, y2), mcd_cmul(mcd_conj(g12), y1));
  assign mdet = mcd_sub(mcd_cmul(a11, a22), mcd_mag2(g12));
  assign zf1 = mcd_add(mcd_cmul(mcd_conj(h11), r1), mcd_cmul(h01, r2c));
  assign zf2 = mcd_sub(mcd_cmul(h00, r2c), mcd_cmul(mcd_conj(h10), r1));
  assign zdet = mcd_add(mcd_cmul(h00, mcd_conj(h11)), mcd_cmul(h01, mcd_conj(h10)));
  assign sgl = mcd_cmul(mcd_conj(q.f_h1), q.f_r);
  assign sgl_g = mcd_mag2(q.f_h1);

  always_comb
  begin
    mcd_cpx_t s_est;
    mcd_cpx_t d_est;
    mcd_cpx_t fs_n;
    mcd_cpx_t fd_n;
    mcd_cell_out_t c1;
    mcd_cell_out_t c2;
    logic old_tag;
    logic cls_use;
    logic nsum;
    logic ndif;
    n = q;
    s_est = est.s;
    d_est = est.d;
    c1 = '{val: y1, gain: g11};
    c2 = '{val: mcd_conj(y2), gain: g22};
    cls_use = in_cell.sof_frame ? CLS_SUM : q.cls;
    // Stage 0: take a cell, read both memories at its carrier.
    n.s1_vld = acc || (q.st == MCD_FLUSH);
    n.s1_old = (q.st == MCD_FLUSH) || (acc && q.have_prev);
    n.s1_npil = acc && in_cell.pilot;
    n.s1_ncls = cls_use;
    n.s1_ntag = q.tag;
    n.s1_nval = in_cell.val;
    n.s1_k = q.k;
    if (q.st == MCD_RUN)
    begin
      n.rdy = 1'b1;
      if (acc)
      begin
        n.cls = cls_use;
        n.k = q.k + 1'b1;
        if (in_cell.eof_sym)
        begin
          n.k = '0;
          n.len = {1'b0, q.k} + 1'b1;
          n.have_prev = 1'b1;
          n.tag = ~q.tag;
          n.cls = ~cls_use;
          // Closing symbol followed by a foreign part: flush it with held values.
          if (in_cell.closing && fef_between)
          begin
            n.st = MCD_FLUSH;
            n.rdy = 1'b0;
          end
        end
      end
    end
    else
    begin
      n.rdy = 1'b0;
      n.k = q.k + 1'b1;
      if ({1'b0, q.k} == q.len - 1'b1)
      begin
        n.k = '0;
        n.st = MCD_RUN;
        n.rdy = 1'b1;
        n.have_prev = 1'b0;
      end
    end
    // Stage 1: temporal then frequency interpolation for the buffered symbol.
    old_tag = ~q.s1_ntag;
    nsum = q.s1_npil && (q.s1_ncls == CLS_SUM);
    ndif = q.s1_npil && (q.s1_ncls == CLS_DIFF);
    if (!(est.s_ok && est.s_tag == old_tag) && nsum)
    begin
      s_est = est.s_ok ? mcd_avg(est.s, q.s1_nval) : q.s1_nval;
    end
    if (!(est.d_ok && est.d_tag == old_tag) && ndif)
    begin
      d_est = est.d_ok ? mcd_avg(est.d, q.s1_nval) : q.s1_nval;
    end
    // Each class sits on all pilot carriers of every other symbol; hold across data carriers.
    fs_n = (est.s_ok || est.d_ok) ? s_est : q.fs;
    fd_n = (est.s_ok || est.d_ok) ? d_est : q.fd;
    est_wr = est;
    if (nsum)
    begin
      est_wr.s = q.s1_nval;
      est_wr.s_tag = q.s1_ntag;
      est_wr.s_ok = 1'b1;
    end
    if (ndif)
    begin
      est_wr.d = q.s1_nval;
      est_wr.d_tag = q.s1_ntag;
      est_wr.d_ok = 1'b1;
    end
    tab_we = q.s1_vld && q.s1_npil;
    n.s2_vld = q.s1_vld && q.s1_old;
    if (n.s2_vld)
    begin
      n.fs = fs_n;
      n.fd = fd_n;
      n.s2_r = buf_rd.val;
      n.s2_pil = buf_rd.pilot;
      n.s2_eos = buf_rd.eos;
      n.s2_h1 = mcd_add(fs_n, fd_n);
      n.s2_h2 = mcd_sub(fs_n, fd_n);
    end
    // Stage 2: pairing and recombination; relies on the group-two cell swap.
    unique case (dec_mode)
      MCD_DEC_ZF:
      begin
        c1 = '{val: zf1, gain: zdet};
        c2 = '{val: mcd_conj(zf2), gain: mcd_conj(zdet)};
      end
      MCD_DEC_MMSE:
      begin
        c1 = '{val: mm1, gain: mdet};
        c2 = '{val: mcd_conj(mm2), gain: mdet};
      end
      default:
      begin
        c1 = '{val: y1, gain: g11};
        c2 = '{val: mcd_conj(y2), gain: g22};
      end
    endcase
    n.o_vld = 1'b0;
    if (q.p_vld)
    begin
      n.o_vld = 1'b1;
      n.o = q.p;
      n.p_vld = 1'b0;
    end
    if (q.s2_vld && !q.s2_pil)
    begin
      if (q.f_vld)
      begin
        n.o_vld = 1'b1;
        n.o = c1;
        n.p = c2;
        n.p_vld = 1'b1;
        n.f_vld = 1'b0;
      end
      else
      begin
        n.f_vld = 1'b1;
        n.f_r = q.s2_r;
        n.f_h1 = q.s2_h1;
        n.f_h2 = q.s2_h2;
      end
    end
    else if (q.s2_vld && q.s2_eos && q.f_vld)
    begin
      // An unpaired cell at symbol end leaves alone with a single-path combine.
      n.f_vld = 1'b0;
      if (q.p_vld)
      begin
        n.p = '{val: sgl, gain: sgl_g};
        n.p_vld = 1'b1;
      end
      else
      begin
        n.o = '{val: sgl, gain: sgl_g};
        n.o_vld = 1'b1;
      end
    end
    n.gi_flt = (gi_sel > MCD_GI_LIMIT);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign in_ready = q.rdy;
  assign out_vld = q.o_vld;
  assign out_cell = q.o;
  assign gi_fault = q.gi_flt;

endmodule : mcd_miso_decoder

// ==== logic/mcd_ram.sv ====
// Simple dual-port memory with read-first behaviour and a registered read port.
`timescale 1ns/1ps
module mcd_ram #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk, // Datapath clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic we, // Write strobe.
  input wire logic [AW-1:0] waddr, // Write address.
  input wire logic [W-1:0] wdata, // Write data.
  input wire logic [AW-1:0] raddr, // Read address.
  output logic [W-1:0] rdata_q // Read data, one cycle after the address.
);

  logic [W-1:0] mem [DEPTH];

  // Reset clears every word, so valid flags kept inside the words start known.
  // A read and write to the same word in one cycle returns the old word.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else
    begin
      rdata_q <= mem[raddr];
      if (we)
      begin
        mem[waddr] <= wdata;
      end
    end
  end

endmodule : mcd_ram

// ==== sim/mcd_miso_decoder_chk.sv ====
// Port checker for the MISO estimator and pair decoder.
`timescale 1ns/1ps
module mcd_miso_decoder_chk (
  input wire logic clk, // Clock.
  input wire logic arst_n, // Reset.
  input wire logic in_vld, // Cell valid.
  input wire mcd_pkg::mcd_cell_in_t in_cell, // Cell.
  input wire logic fef_between, // Foreign part.
  input wire mcd_pkg::mcd_dec_mode_t dec_mode, // Method.
  input wire logic signed [15:0] noise_var, // Noise.
  input wire mcd_pkg::mcd_gi_t gi_sel, // Guard.
  input wire logic in_ready, // Ready.
  input wire logic out_vld, // Out valid.
  input wire mcd_pkg::mcd_cell_out_t out_cell, // Out cell.
  input wire logic gi_fault // Guard fault.
);
  import mcd_pkg::*;
  logic take_fef;
  logic [3:0] age_q;
  mcd_dec_mode_t mode_q;
  assign take_fef = in_vld && in_ready && in_cell.eof_sym && in_cell.closing && fef_between;
  // Counts cycles since the method last changed, so results in flight are skipped.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= MCD_DEC_CT;
      age_q <= 4'h0;
    end
    else
    begin
      mode_q <= dec_mode;
      age_q <= (dec_mode != mode_q) ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_flush;
    !in_ready [*8] ##1 !in_ready;
  endsequence
  property p_gi_fault;
    $past(arst_n) |-> gi_fault == ($past(gi_sel) > MCD_GI_LIMIT);
  endproperty
  a_gi_fault: assert property (p_gi_fault) else $error("guard flag wrong");
  property p_gi_hold;
    gi_sel <= MCD_GI_LIMIT ##1 gi_sel <= MCD_GI_LIMIT |-> !gi_fault;
  endproperty
  a_gi_hold: assert property (p_gi_hold) else $error("guard flag set");
  property p_flush_len;
    take_fef |=> s_flush;
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("flush too short");
  property p_flush_end;
    take_fef |-> ##10 in_ready;
  endproperty
  a_flush_end: assert property (p_flush_end) else $error("flush too long");
  property p_ready_steady;
    in_ready && !take_fef |=> in_ready;
  endproperty
  a_ready_steady: assert property (p_ready_steady) else $error("ready dropped");
  property p_flush_out;
    take_fef |-> ##[1:14] out_vld;
  endproperty
  a_flush_out: assert property (p_flush_out) else $error("no flush output");
  property p_out_cause;
    out_vld |-> $past(in_vld && in_ready, 3) || $past(in_vld && in_ready, 4)
      || $past(!in_ready, 3) || $past(!in_ready, 4);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output without input");
  property p_ct_gain;
    out_vld && dec_mode == MCD_DEC_CT && age_q > 4'h6 |-> out_cell.gain.im == 16'sh0;
  endproperty
  a_ct_gain: assert property (p_ct_gain) else $error("gain not real");
endmodule : mcd_miso_decoder_chk
bind mcd_miso_decoder mcd_miso_decoder_chk u_chk (.clk, .arst_n, .in_vld, .in_cell,
  .fef_between, .dec_mode, .noise_var, .gi_sel, .in_ready, .out_vld, .out_cell, .gi_fault);

// ==== sim/mcd_miso_decoder_tb_top.sv ====
// Self-checking bench for the MISO estimator and pair decoder.
`timescale 1ns/1ps
module mcd_miso_decoder_tb_top;
  import mcd_pkg::*;
  logic clk;
  logic arst_n;
  logic in_vld;
  mcd_cell_in_t in_cell;
  logic fef_between;
  mcd_dec_mode_t dec_mode;
  logic signed [15:0] noise_var;
  mcd_gi_t gi_sel;
  logic in_ready;
  logic out_vld;
  mcd_cell_out_t out_cell;
  logic gi_fault;
  mcd_cell_out_t outq[$];
  int fail_count;
  int tests_run;
  int low_cnt;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  mcd_src u_src (.clk, .in_ready, .in_vld, .in_cell, .fef_between);
  mcd_miso_decoder u_dut (.clk, .arst_n, .in_vld, .in_cell, .fef_between, .dec_mode,
    .noise_var, .gi_sel, .in_ready, .out_vld, .out_cell, .gi_fault);
  always @(posedge clk)
  begin
    if (out_vld === 1'b1)
      outq.push_back(out_cell);
    if (arst_n === 1'b1 && in_ready !== 1'b1)
      low_cnt++;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Judges the six cells of the last decoded symbol; pairs alternate first, second.
  task automatic check_sym(input logic [15:0] y1, input logic [15:0] y2, input logic [15:0] g);
    int b;
    b = outq.size() - 6;
    check("cells ready", 16'h0001, {15'h0, b >= 0});
    for (int p = 0; p < 6 && b >= 0; p++)
    begin
      check("cell re", p[0] ? y2 : y1, outq[b + p].val.re);
      check("cell im", 16'h0000, outq[b + p].val.im);
      check("gain re", g, outq[b + p].gain.re);
      check("gain im", 16'h0000, outq[b + p].gain.im);
    end
  endtask : check_sym
  task automatic t_gi();
    for (int i = 0; i < 7; i++)
    begin
      gi_sel <= mcd_gi_t'(i);
      repeat (2) @(posedge clk);
      check("guard fault", {15'h0, i > 4}, {15'h0, gi_fault});
    end
    gi_sel <= MCD_GI_1_8;
    $display("test guard done");
  endtask : t_gi
  task automatic t_mode(input mcd_dec_mode_t m, input logic sof, input logic [15:0] y1,
    input logic [15:0] y2, input logic [15:0] g);
    dec_mode <= m;
    u_src.send_sym(sof, 1'b0, 1'b0);
    u_src.send_sym(1'b0, 1'b0, 1'b0);
    u_src.send_sym(1'b0, 1'b0, 1'b0);
    u_src.stop();
    repeat (12) @(posedge clk);
    check_sym(y1, y2, g);
    $display("test mode %0d done", m);
  endtask : t_mode
  task automatic t_close();
    low_cnt = 0;
    // The expected values below are those of the plain recombination.
    dec_mode <= MCD_DEC_CT;
    u_src.send_sym(1'b0, 1'b1, 1'b0);
    u_src.send_sym(1'b1, 1'b0, 1'b0);
    u_src.stop();
    repeat (12) @(posedge clk);
    check("ready lows", 16'h0000, 16'(low_cnt));
    check_sym(16'h1800, 16'hF800, 16'h2800);
    u_src.send_sym(1'b0, 1'b1, 1'b1);
    u_src.stop();
    repeat (20) @(posedge clk);
    check("flush lows", 16'h0009, 16'(low_cnt));
    check_sym(16'h1800, 16'hF800, 16'h2800);
    $display("test closing done");
  endtask : t_close
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    arst_n = 1'b0;
    dec_mode = MCD_DEC_CT;
    noise_var = 16'sh0800;
    gi_sel = MCD_GI_1_8;
    fail_count = 0;
    tests_run = 0;
    low_cnt = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_gi();
    t_mode(MCD_DEC_CT, 1'b1, 16'h1800, 16'hF800, 16'h2800);
    t_mode(MCD_DEC_ZF, 1'b0, 16'h1800, 16'hF800, 16'h2800);
    t_mode(MCD_DEC_MMSE, 1'b0, 16'h1200, 16'hFA00, 16'h2400);
    t_close();
    report_and_stop();
  end
endmodule : mcd_miso_decoder_tb_top

// ==== sim/mcd_src.sv ====
// Upstream demodulator model streaming nine-carrier symbols.
`timescale 1ns/1ps
module mcd_src (
  input wire logic clk, // Clock.
  input wire logic in_ready, // Ready.
  output logic in_vld, // Cell valid.
  output mcd_pkg::mcd_cell_in_t in_cell, // Cell.
  output logic fef_between // Foreign part.
);
  import mcd_pkg::*;
  logic cls_q;
  initial
  begin
    in_vld = 1'b0;
    in_cell = '0;
    fef_between = 1'b0;
    cls_q = CLS_SUM;
  end
  task automatic send_sym(input logic sof, input logic clo, input logic fef);
    int nd;
    mcd_cell_in_t c;
    nd = 0;
    if (sof)
      cls_q = CLS_SUM;
    for (int k = 0; k < 9; k++)
    begin
      c = '0;
      c.pilot = (k == 0) || (k == 4) || (k == 8);
      if (c.pilot)
        c.val.re = (cls_q == CLS_SUM) ? 16'sh2000 : 16'sh1000;
      else
      begin
        c.val.re = nd[0] ? 16'sh0000 : 16'sh2000;
        nd++;
      end
      c.sof_frame = sof && (k == 0);
      c.eof_sym = (k == 8);
      c.closing = clo;
      in_vld <= 1'b1;
      in_cell <= c;
      fef_between <= fef;
      do
        @(posedge clk);
      while (in_ready !== 1'b1);
    end
    cls_q = ~cls_q;
  endtask : send_sym
  task automatic stop();
    in_vld <= 1'b0;
    in_cell <= ~in_cell;
  endtask : stop
endmodule : mcd_src
